// ---- rtl/dtd_pkg.sv ----
/*
 * package for the data transfer decode/execute block: instruction classes,
 * operation codes, addressing modes, flag positions and sizes.
 * assumes one system clock; the op, mode and size fields are already split out
 * of the instruction word by the fetch stage.
 */
package dtd_pkg;

	// instruction classes and how many types the core has
	localparam logic [7:0] DTD_NUM_TYPES = 8'h39;
	typedef enum logic [2:0] {
		DTD_CLS_XFER   = 3'h0,
		DTD_CLS_ARITH  = 3'h1,
		DTD_CLS_LOGIC  = 3'h2,
		DTD_CLS_SHIFT  = 3'h3,
		DTD_CLS_BIT    = 3'h4,
		DTD_CLS_BRANCH = 3'h5,
		DTD_CLS_SYSCTL = 3'h6,
		DTD_CLS_BLOCK  = 3'h7
	} dtd_class_t;

	// transfer group operations
	typedef enum logic [2:0] {
		DTD_OP_MOVE  = 3'h0,
		DTD_OP_PUSH  = 3'h1,
		DTD_OP_POP   = 3'h2,
		DTD_OP_PSTO  = 3'h3,
		DTD_OP_PLDO  = 3'h4,
		DTD_OP_BCOND = 3'h5
	} dtd_op_t;

	// addressing modes of the move operation
	typedef enum logic [2:0] {
		DTD_AM_REG    = 3'h0,
		DTD_AM_IND    = 3'h1,
		DTD_AM_DISP16 = 3'h2,
		DTD_AM_ABS16  = 3'h3,
		DTD_AM_ABS8   = 3'h4,
		DTD_AM_IMM    = 3'h5,
		DTD_AM_PREDEC = 3'h6,
		DTD_AM_POSTIN = 3'h7
	} dtd_amode_t;

	// register file, stack pointer index, short absolute page
	localparam logic [2:0]  DTD_SP_INDEX   = 3'h7;
	localparam logic [7:0]  DTD_ABS8_PAGE  = 8'hff;
	localparam logic [15:0] DTD_STEP_BYTE  = 16'h0001;
	localparam logic [15:0] DTD_STEP_WORD  = 16'h0002;
	localparam logic [15:0] DTD_WORD_ALIGN = 16'hfffe;

	// flag positions in the condition flags register
	localparam int DTD_FLAG_C = 0;
	localparam int DTD_FLAG_V = 1;
	localparam int DTD_FLAG_Z = 2;
	localparam int DTD_FLAG_N = 3;
	localparam int DTD_FLAG_I = 7;
	localparam logic [7:0] DTD_FLAGS_RESET = 8'h80;

	// branch conditions (4-bit condition code field)
	localparam logic [3:0] DTD_CC_T  = 4'h0;
	localparam logic [3:0] DTD_CC_F  = 4'h1;
	localparam logic [3:0] DTD_CC_HI = 4'h2;
	localparam logic [3:0] DTD_CC_LS = 4'h3;
	localparam logic [3:0] DTD_CC_CC = 4'h4;
	localparam logic [3:0] DTD_CC_CS = 4'h5;
	localparam logic [3:0] DTD_CC_NE = 4'h6;
	localparam logic [3:0] DTD_CC_EQ = 4'h7;
	localparam logic [3:0] DTD_CC_VC = 4'h8;
	localparam logic [3:0] DTD_CC_VS = 4'h9;
	localparam logic [3:0] DTD_CC_PL = 4'ha;
	localparam logic [3:0] DTD_CC_MI = 4'hb;
	localparam logic [3:0] DTD_CC_GE = 4'hc;
	localparam logic [3:0] DTD_CC_LT = 4'hd;
	localparam logic [3:0] DTD_CC_GT = 4'he;
	localparam logic [3:0] DTD_CC_LE = 4'hf;

endpackage

// ---- rtl/dtd_regfile.sv ----
/*
 * eight 16-bit general registers with one registered read port and one write
 * port with byte enables. register seven serves as the stack pointer.
 * assumes the caller allows one cycle of read latency.
 */
module dtd_regfile
	import dtd_pkg::*;
(
	// clock
	input  wire logic        clk_sys_in,
	// read port
	input  wire logic [2:0]  rd_sel_in,
	output logic      [15:0] rd_data_out,
	// write port
	input  wire logic        wr_en_in,
	input  wire logic [2:0]  wr_sel_in,
	input  wire logic [1:0]  wr_be_in,
	input  wire logic [15:0] wr_data_in
);

	logic [15:0] regs [8];   // register storage, not cleared by reset

	// write with byte lanes
	always_ff @(posedge clk_sys_in) begin
		if (wr_en_in && wr_be_in[1]) begin
			regs[wr_sel_in][15:8] <= wr_data_in[15:8];
		end
		if (wr_en_in && wr_be_in[0]) begin
			regs[wr_sel_in][7:0] <= wr_data_in[7:0];
		end
	end

	// registered read
	always_ff @(posedge clk_sys_in) begin
		rd_data_out <= regs[rd_sel_in];
	end

endmodule

// ---- rtl/dtd_xfer.sv ----
/*
 * execute logic for the data transfer group: move in all its addressing modes,
 * push and pop through the stack pointer, the conditional branch test, and a
 * classifier for all instruction types. a request is taken when idle; the
 * block reads registers, accesses memory and writes back, then pulses done.
 * assumes memory answers each request with a one-cycle ack, data valid with it.
 */
// Functional notes
// - classify into 57 types, eight classes
// - move between registers, memory, immediate
// - byte and word share most modes
// - short absolute only for byte moves
// - peripheral sync transfers are refused as illegal
// - push is word predecrement store via SP
// - pop is word postincrement load via SP
// - branch taken only if condition holds
// - step by one or two, pre/post
// - word access clears address bit zero
// - register seven is word stack pointer
module dtd_xfer
	import dtd_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// instruction request
	input  wire logic        req_valid_in,
	input  wire logic [2:0]  req_op_in,
	input  wire logic [2:0]  req_mode_in,
	input  wire logic        req_word_in,
	input  wire logic        req_to_mem_in,
	input  wire logic [2:0]  req_rd_in,
	input  wire logic [2:0]  req_rs_in,
	input  wire logic [15:0] req_ext_in,
	input  wire logic [3:0]  req_cc_in,
	input  wire logic [5:0]  req_type_in,
	// instruction answer
	output logic             busy_out,
	output logic             done_out,
	output logic             illegal_out,
	output logic             branch_taken_out,
	output logic      [2:0]  class_out,
	output logic      [7:0]  flags_out,
	// memory side
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic             mem_word_out,
	output logic      [15:0] mem_addr_out,
	output logic      [15:0] mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [15:0] mem_rdata_in
);

	typedef enum logic [5:0] {
		DTD_ST_IDLE = 6'h01,
		DTD_ST_RDA  = 6'h02,
		DTD_ST_RDB  = 6'h04,
		DTD_ST_MEM  = 6'h08,
		DTD_ST_WB   = 6'h10,
		DTD_ST_WB2  = 6'h20
	} dtd_state_t;

	dtd_state_t  state;        // sequencer
	dtd_state_t  next_state;   // sequencer next
	logic [2:0]  op;           // latched operation
	logic [2:0]  mode;         // latched addressing mode
	logic        word;         // latched size
	logic        to_mem;       // latched direction
	logic [2:0]  rd;           // data register
	logic [2:0]  rs;           // address register
	logic [15:0] ext;          // displacement, absolute or immediate
	logic [15:0] data_val;     // value being moved
	logic [15:0] addr_base;    // address register contents
	logic [15:0] wb_val;       // value for writeback
	logic [2:0]  wb_sel;       // writeback register
	logic [1:0]  wb_be;        // writeback byte lanes
	logic        wb_en;        // writeback strobe
	logic [15:0] rf_rdata;     // register file read data
	logic [2:0]  rf_rsel;      // register file read select
	logic        addr_upd;     // second writeback of address register
	logic        illegal_req;  // request refused at the door

	// step size for auto modes
	function automatic logic [15:0] step(input logic w);
		return w ? DTD_STEP_WORD : DTD_STEP_BYTE;
	endfunction

	// word accesses drop address bit zero
	function automatic logic [15:0] align(input logic [15:0] a, input logic w);
		return w ? (a & DTD_WORD_ALIGN) : a;
	endfunction

	// condition evaluation
	function automatic logic cond_met(input logic [3:0] cc, input logic [7:0] f);
		logic c, v, z, n;
		c = f[DTD_FLAG_C];
		v = f[DTD_FLAG_V];
		z = f[DTD_FLAG_Z];
		n = f[DTD_FLAG_N];
		case (cc)
			DTD_CC_T:  return 1'b1;
			DTD_CC_F:  return 1'b0;
			DTD_CC_HI: return ~(c | z);
			DTD_CC_LS: return c | z;
			DTD_CC_CC: return ~c;
			DTD_CC_CS: return c;
			DTD_CC_NE: return ~z;
			DTD_CC_EQ: return z;
			DTD_CC_VC: return ~v;
			DTD_CC_VS: return v;
			DTD_CC_PL: return ~n;
			DTD_CC_MI: return n;
			DTD_CC_GE: return ~(n ^ v);
			DTD_CC_LT: return n ^ v;
			DTD_CC_GT: return ~(z | (n ^ v));
			default:   return z | (n ^ v);
		endcase
	endfunction

	// type number to class: transfer 0-2, arith 3-16, logic 17-20, shift 21-28,
	// bit 29-42, branch 43-47, system 48-55, block 56
	function automatic logic [2:0] classify(input logic [5:0] t);
		if (t < 6'h03) return DTD_CLS_XFER;
		else if (t < 6'h11) return DTD_CLS_ARITH;
		else if (t < 6'h15) return DTD_CLS_LOGIC;
		else if (t < 6'h1d) return DTD_CLS_SHIFT;
		else if (t < 6'h2b) return DTD_CLS_BIT;
		else if (t < 6'h30) return DTD_CLS_BRANCH;
		else if (t < 6'h38) return DTD_CLS_SYSCTL;
		else return DTD_CLS_BLOCK;
	endfunction

	// mode is a memory access
	wire is_mem = (mode != DTD_AM_REG) && (mode != DTD_AM_IMM);
	// effective address before alignment; only used in RDB, where the address
	// register is still on the read port and not yet in addr_base
	logic [15:0] ea;
	always_comb begin
		case (mode)
			DTD_AM_DISP16: ea = rf_rdata + ext;
			DTD_AM_ABS16:  ea = ext;
			DTD_AM_ABS8:   ea = {DTD_ABS8_PAGE, ext[7:0]};
			DTD_AM_PREDEC: ea = rf_rdata - step(word);
			default:       ea = rf_rdata;
		endcase
	end

	// register file
	dtd_regfile u_regs (
		.clk_sys_in  (clk_sys_in),
		.rd_sel_in   (rf_rsel),
		.rd_data_out (rf_rdata),
		.wr_en_in    (wb_en),
		.wr_sel_in   (wb_sel),
		.wr_be_in    (wb_be),
		.wr_data_in  (wb_val)
	);

	// read select: data register first, then address register
	assign rf_rsel = (state == DTD_ST_IDLE) ? req_rd_in : rs;

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			DTD_ST_IDLE: if (req_valid_in) begin
				next_state = DTD_ST_RDA;
			end
			DTD_ST_RDA:  next_state = DTD_ST_RDB;
			DTD_ST_RDB:  next_state = is_mem ? DTD_ST_MEM : DTD_ST_WB;
			DTD_ST_MEM:  if (mem_ack_in) begin
				next_state = DTD_ST_WB;
			end
			DTD_ST_WB:   next_state = addr_upd ? DTD_ST_WB2 : DTD_ST_IDLE;
			DTD_ST_WB2:  next_state = DTD_ST_IDLE;
			default:     next_state = DTD_ST_IDLE;
		endcase
	end

	// state register; unimplemented or illegal requests never leave idle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= DTD_ST_IDLE;
		end else if (state == DTD_ST_IDLE && (illegal_req || req_op_in == DTD_OP_BCOND)) begin
			state <= DTD_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// request legality
	always_comb begin
		illegal_req = 1'b0;
		if (req_op_in == DTD_OP_PSTO || req_op_in == DTD_OP_PLDO) illegal_req = 1'b1;
		if (req_op_in == DTD_OP_MOVE && req_mode_in == DTD_AM_ABS8 && req_word_in)
			illegal_req = 1'b1;
		if (req_op_in == DTD_OP_MOVE && !req_word_in && req_rs_in == DTD_SP_INDEX &&
		    (req_mode_in == DTD_AM_PREDEC || req_mode_in == DTD_AM_POSTIN))
			illegal_req = 1'b1;
		// store to immediate makes no sense as memory move; register-direct store is let through
		if (req_op_in == DTD_OP_MOVE && req_to_mem_in && req_mode_in == DTD_AM_IMM)
			illegal_req = 1'b1;
		if (req_op_in > DTD_OP_BCOND) illegal_req = 1'b1;
	end

	// latch the request, mapping push and pop onto word moves through the stack
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			op <= DTD_OP_MOVE;
			mode <= DTD_AM_REG;
			word <= 1'b0;
			to_mem <= 1'b0;
			rd <= 3'h0;
			rs <= 3'h0;
			ext <= 16'h0000;
		end else if (state == DTD_ST_IDLE && req_valid_in) begin
			op <= req_op_in;
			rd <= req_rd_in;
			ext <= req_ext_in;
			case (req_op_in)
				DTD_OP_PUSH: begin
					mode <= DTD_AM_PREDEC;
					word <= 1'b1;
					to_mem <= 1'b1;
					rs <= DTD_SP_INDEX;
				end
				DTD_OP_POP: begin
					mode <= DTD_AM_POSTIN;
					word <= 1'b1;
					to_mem <= 1'b0;
					rs <= DTD_SP_INDEX;
				end
				default: begin
					mode <= req_mode_in;
					word <= req_word_in;
					to_mem <= req_to_mem_in;
					rs <= req_rs_in;
				end
			endcase
		end
	end

	// operand capture: data register in RDA, address register in RDB
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			data_val <= 16'h0000;
			addr_base <= 16'h0000;
		end else if (state == DTD_ST_RDA) begin
			data_val <= rf_rdata;
		end else if (state == DTD_ST_RDB) begin
			addr_base <= rf_rdata;
			if (mode == DTD_AM_REG && !to_mem) data_val <= 16'h0000;
			if (mode == DTD_AM_IMM) data_val <= word ? ext : {8'h00, ext[7:0]};
		end else if (state == DTD_ST_MEM && mem_ack_in && !to_mem) begin
			data_val <= word ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
		end
	end

	// register-direct source value comes from rs in RDB
	wire [15:0] src_val = (mode == DTD_AM_REG && !to_mem) ?
		(word ? addr_base : {8'h00, addr_base[7:0]}) : data_val;

	// memory request stands from MEM entry until ack
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_word_out <= 1'b0;
			mem_addr_out <= 16'h0000;
			mem_wdata_out <= 16'h0000;
		end else if (state == DTD_ST_RDB && is_mem) begin
			// same path for byte and word; word short absolute is refused earlier
			mem_req_out <= 1'b1;
			mem_we_out <= to_mem;
			mem_word_out <= word;
			mem_addr_out <= align(ea, word);
			mem_wdata_out <= word ? data_val : {8'h00, data_val[7:0]};
		end else if (mem_ack_in) begin
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
		end
	end

	// writeback: data register for loads, then address register for auto modes
	assign addr_upd = (mode == DTD_AM_PREDEC) || (mode == DTD_AM_POSTIN);
	always_comb begin
		wb_en = 1'b0;
		wb_sel = rd;
		wb_be = word ? 2'h3 : 2'h1;
		wb_val = src_val;
		if (state == DTD_ST_WB && !to_mem) begin
			wb_en = 1'b1;
		end else if ((state == DTD_ST_WB && to_mem && addr_upd) || state == DTD_ST_WB2) begin
			wb_en = 1'b1;
			wb_sel = rs;
			wb_be = 2'h3;
			wb_val = (mode == DTD_AM_PREDEC) ? addr_base - step(word) : addr_base + step(word);
		end
	end

	// address update of a load happens in WB2, of a store in WB; a store repeats
	// the same value in WB2, which is harmless and keeps both paths one length
	// flags and answer outputs
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= DTD_FLAGS_RESET;
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			branch_taken_out <= 1'b0;
			class_out <= DTD_CLS_XFER;
			busy_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			branch_taken_out <= 1'b0;
			busy_out <= (next_state != DTD_ST_IDLE) && !(state == DTD_ST_IDLE &&
				(illegal_req || req_op_in == DTD_OP_BCOND));
			if (state == DTD_ST_IDLE && req_valid_in) begin
				class_out <= classify(req_type_in);
				if (illegal_req) begin
					done_out <= 1'b1;
					illegal_out <= 1'b1;
				end else if (req_op_in == DTD_OP_BCOND) begin
					done_out <= 1'b1;
					branch_taken_out <= cond_met(req_cc_in, flags_out);
				end
			end
			if (state == DTD_ST_WB) begin
				// N Z from value, V cleared
				flags_out[DTD_FLAG_N] <= word ? src_val[15] : src_val[7];
				flags_out[DTD_FLAG_Z] <= word ? (src_val == 16'h0000) : (src_val[7:0] == 8'h00);
				flags_out[DTD_FLAG_V] <= 1'b0;
			end
			if (next_state == DTD_ST_IDLE && (state == DTD_ST_WB || state == DTD_ST_WB2))
				done_out <= 1'b1;
		end
	end

endmodule

// ---- tb/dtd_mem_model.sv ----
/*
 * byte-wide memory standing on the far side of the transfer block.
 * assumes one request at a time, answered by a one-cycle ack after
 * delay_in idle cycles; read data is valid only with the ack.
 */
module dtd_mem_model (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// request side
	input  wire logic        mem_req_in,
	input  wire logic        mem_we_in,
	input  wire logic        mem_word_in,
	input  wire logic [15:0] mem_addr_in,
	input  wire logic [15:0] mem_wdata_in,
	input  wire logic [1:0]  delay_in,
	// answer side
	output logic             mem_ack_out,
	output logic      [15:0] mem_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [int];  // sparse byte store
	logic [15:0] last_addr;  // address of the last access
	logic [15:0] last_data;  // data of the last write
	int          acc_count;  // accesses answered
	int          wait_cnt;   // idle cycles spent on this request

	// read a byte, unwritten places give a fixed filler
	function automatic logic [7:0] rd8(input int a);
		return mem.exists(a) ? mem[a] : 8'h5a;
	endfunction

	// answer one request; data lines toggle when not valid
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= 16'h0000;
			wait_cnt <= 0;
			acc_count <= 0;
		end else begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= ~mem_rdata_out;
			if (mem_req_in && !mem_ack_out) begin
				if (wait_cnt < delay_in) begin
					wait_cnt <= wait_cnt + 1;
				end else begin
					wait_cnt <= 0;
					mem_ack_out <= 1'b1;
					acc_count <= acc_count + 1;
					last_addr <= mem_addr_in;
					if (mem_we_in) begin
						last_data <= mem_wdata_in;
						// address kept as given, so a missing alignment shows
						if (mem_word_in) begin
							mem[mem_addr_in] = mem_wdata_in[15:8];
							mem[mem_addr_in + 1] = mem_wdata_in[7:0];
						end else begin
							mem[mem_addr_in] = mem_wdata_in[7:0];
						end
					end else begin
						mem_rdata_out <= mem_word_in ?
							{rd8(mem_addr_in), rd8(mem_addr_in + 1)} : {8'h00, rd8(mem_addr_in)};
					end
				end
			end
		end
	end
endmodule

// ---- tb/dtd_xfer_asserts.sv ----
/*
 * timing and refusal checks for the transfer execute block.
 * assumes it is bound to dtd_xfer and sees only its ports.
 */
module dtd_xfer_asserts
	import dtd_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	input wire logic        req_valid_in,
	input wire logic [2:0]  req_op_in,
	input wire logic [2:0]  req_mode_in,
	input wire logic        req_word_in,
	input wire logic [2:0]  req_rs_in,
	input wire logic [15:0] req_ext_in,
	input wire logic [3:0]  req_cc_in,
	input wire logic        busy_out,
	input wire logic        done_out,
	input wire logic        illegal_out,
	input wire logic        branch_taken_out,
	input wire logic [7:0]  flags_out,
	input wire logic        mem_req_out,
	input wire logic        mem_we_out,
	input wire logic        mem_word_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic        mem_ack_in
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire take = req_valid_in && !busy_out;  // request accepted this edge
	wire mv   = take && req_op_in == DTD_OP_MOVE;

	// short absolute address lands in the top page
	property abs8_page_p;
		logic [7:0] e;
		(mv && req_mode_in == DTD_AM_ABS8 && !req_word_in, e = req_ext_in[7:0])
			|-> ##3 mem_req_out && mem_addr_out == {DTD_ABS8_PAGE, e};
	endproperty

	periph_refused_a: assert property (take && (req_op_in == DTD_OP_PSTO ||
		req_op_in == DTD_OP_PLDO) |=> done_out && illegal_out && !mem_req_out)
		else $error("peripheral transfer not refused");
	abs8_word_a: assert property (mv && req_mode_in == DTD_AM_ABS8 && req_word_in
		|=> done_out && illegal_out) else $error("word short absolute accepted");
	abs8_page_a: assert property (abs8_page_p)
		else $error("short absolute address wrong");
	sp_byte_a: assert property (mv && !req_word_in && req_rs_in == DTD_SP_INDEX &&
		(req_mode_in == DTD_AM_PREDEC || req_mode_in == DTD_AM_POSTIN) |=> illegal_out)
		else $error("byte stack access accepted");
	word_align_a: assert property (mem_req_out && mem_word_out |-> !mem_addr_out[0])
		else $error("odd word address");
	push_store_a: assert property (take && req_op_in == DTD_OP_PUSH
		|-> ##3 mem_req_out && mem_we_out && mem_word_out) else $error("push not a word store");
	pop_load_a: assert property (take && req_op_in == DTD_OP_POP
		|-> ##3 mem_req_out && !mem_we_out && mem_word_out) else $error("pop not a word load");
	branch_true_a: assert property (take && req_op_in == DTD_OP_BCOND &&
		req_cc_in == DTD_CC_T |=> done_out && branch_taken_out) else $error("branch not taken");
	mem_hold_a: assert property (mem_req_out && !mem_ack_in
		|=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
		else $error("memory request dropped early");
	carry_kept_a: assert property ($stable(flags_out[DTD_FLAG_C]))
		else $error("carry flag changed");

	// main scenarios reached
	c_push: cover property (take && req_op_in == DTD_OP_PUSH);
	c_slow: cover property (mem_req_out [*4]);
	c_ill: cover property (illegal_out);
endmodule

bind dtd_xfer dtd_xfer_asserts dtd_xfer_asserts_i (.*);

// ---- tb/dtd_xfer_bench.sv ----
/*
 * self-checking bench for the transfer execute block with a memory model.
 * assumes registers start unknown; t_steps and t_stack reuse registers loaded by t_move.
 */
module dtd_xfer_bench;
	import dtd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0;
	logic [2:0] req_op_in = 3'h0, req_mode_in = 3'h0, req_rd_in = 3'h0, req_rs_in = 3'h0;
	logic req_word_in = 1'b0, req_to_mem_in = 1'b0, busy_out, done_out, illegal_out;
	logic branch_taken_out, mem_req_out, mem_we_out, mem_word_out, mem_ack_in, got_ill;
	logic [15:0] req_ext_in = 16'h0000, mem_addr_out, mem_wdata_out, mem_rdata_in;
	logic [3:0] req_cc_in = 4'h0;
	logic [5:0] req_type_in = 6'h00;
	logic [2:0] class_out;
	logic [7:0] flags_out;
	logic [1:0] delay = 2'h0;  // memory answer delay
	int fails = 0, check_count = 0, cycles = 0, n0;

	dtd_xfer dtd_xfer_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
		.req_op_in(req_op_in), .req_mode_in(req_mode_in), .req_word_in(req_word_in),
		.req_to_mem_in(req_to_mem_in), .req_rd_in(req_rd_in), .req_rs_in(req_rs_in),
		.req_ext_in(req_ext_in), .req_cc_in(req_cc_in), .req_type_in(req_type_in),
		.busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out),
		.branch_taken_out(branch_taken_out), .class_out(class_out), .flags_out(flags_out),
		.mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_word_out(mem_word_out),
		.mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
		.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
	dtd_mem_model dtd_mem_model_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.mem_req_in(mem_req_out), .mem_we_in(mem_we_out), .mem_word_in(mem_word_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .delay_in(delay),
		.mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

	// 250 MHz clock and a ceiling on run time
	always #2 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// one request, held one edge, then wait for the done pulse
	task automatic issue(input logic [2:0] op, md, input logic wd, tm,
		input logic [2:0] rd, rs, input logic [15:0] ext, input logic [5:0] ty = 6'h00);
		int n;
		@(negedge clk_sys_in);
		{req_op_in, req_mode_in, req_word_in, req_to_mem_in} = {op, md, wd, tm};
		{req_rd_in, req_rs_in, req_ext_in, req_type_in} = {rd, rs, ext, ty};
		req_valid_in = 1'b1;
		@(negedge clk_sys_in);
		req_valid_in = 1'b0;
		n = 0;
		while (done_out !== 1'b1 && n < 40) begin
			@(negedge clk_sys_in);
			n++;
		end
		check("done", 16'(n < 40), 16'h1);
		check("busy", 16'(busy_out), 16'h0);
		got_ill = illegal_out;
	endtask

	task automatic last_is(input logic [15:0] a, d);
		check("addr", dtd_mem_model_i.last_addr, a);
		check("data", dtd_mem_model_i.last_data, d);
	endtask

	// immediates, register copy, odd word address, flags
	task automatic t_move();
		issue(DTD_OP_MOVE, DTD_AM_IMM, 1, 0, 1, 0, 16'h8123);
		check("flags", 16'(flags_out[3:0]), 16'h0008);
		issue(DTD_OP_MOVE, DTD_AM_ABS16, 1, 1, 1, 0, 16'h1001);
		last_is(16'h1000, 16'h8123);
		issue(DTD_OP_MOVE, DTD_AM_REG, 1, 0, 6, 1, 16'h0000);
		issue(DTD_OP_MOVE, DTD_AM_IMM, 1, 0, 2, 0, 16'h3000);
		issue(DTD_OP_MOVE, DTD_AM_DISP16, 1, 1, 6, 2, 16'h0010);
		last_is(16'h3010, 16'h8123);
		issue(DTD_OP_MOVE, DTD_AM_IND, 1, 0, 5, 2, 16'h0000);
		issue(DTD_OP_MOVE, DTD_AM_ABS16, 1, 1, 5, 0, 16'h0400);
		last_is(16'h0400, 16'h5a5a);
	endtask

	// byte steps of one around the same register
	task automatic t_steps();
		issue(DTD_OP_MOVE, DTD_AM_PREDEC, 0, 1, 1, 2, 16'h0000);
		last_is(16'h2fff, 16'h0023);
		issue(DTD_OP_MOVE, DTD_AM_POSTIN, 0, 0, 3, 2, 16'h0000);
		check("addr", dtd_mem_model_i.last_addr, 16'h2fff);
		issue(DTD_OP_MOVE, DTD_AM_POSTIN, 0, 0, 3, 2, 16'h0000);
		check("addr", dtd_mem_model_i.last_addr, 16'h3000);
		issue(DTD_OP_MOVE, DTD_AM_ABS8, 0, 1, 1, 0, 16'h0034);
		last_is(16'hff34, 16'h0023);
	endtask

	// push and pop with a slow memory; stack set up word sized
	task automatic t_stack();
		delay = 2'h3;
		issue(DTD_OP_MOVE, DTD_AM_IMM, 1, 0, 7, 0, 16'h2000);
		issue(DTD_OP_PUSH, DTD_AM_REG, 1, 1, 1, 7, 16'h0000);
		last_is(16'h1ffe, 16'h8123);
		issue(DTD_OP_POP, DTD_AM_REG, 1, 0, 4, 7, 16'h0000);
		issue(DTD_OP_PUSH, DTD_AM_REG, 1, 1, 4, 7, 16'h0000);
		last_is(16'h1ffe, 16'h8123);
		delay = 2'h0;
	endtask

	// one case of each refusal rule: flagged and no memory traffic
	task automatic t_refused();
		logic [10:0] bad [6] = '{{3'h3, 3'h0, 2'b00, 3'h1}, {3'h4, 3'h0, 2'b00, 3'h1},
			{3'h0, 3'h4, 2'b11, 3'h0}, {3'h0, 3'h6, 2'b01, 3'h7},
			{3'h0, 3'h5, 2'b11, 3'h0}, {3'h6, 3'h0, 2'b10, 3'h1}};
		n0 = dtd_mem_model_i.acc_count;
		foreach (bad[i]) begin
			issue(bad[i][10:8], bad[i][7:5], bad[i][4], bad[i][3], 1, bad[i][2:0], 16'h0020);
			check("illegal", 16'(got_ill), 16'h1);
		end
		check("accesses", 16'(dtd_mem_model_i.acc_count - n0), 16'h0);
	endtask

	// expected branch decision from N Z V C
	function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
		logic r;
		case (cc[3:1])
			3'h0: r = 1'b1;
			3'h1: r = !(f[0] | f[2]);
			3'h2: r = !f[0];
			3'h3: r = !f[2];
			3'h4: r = !f[1];
			3'h5: r = !f[3];
			3'h6: r = !(f[3] ^ f[1]);
			default: r = !(f[2] | (f[3] ^ f[1]));
		endcase
		return cc[0] ? !r : r;
	endfunction

	// all conditions under two flag sets, then every type's class
	task automatic t_branch();
		int lim [8] = '{3, 17, 21, 29, 43, 48, 56, 57};
		int e;
		for (int k = 0; k < 2; k++) begin
			issue(DTD_OP_MOVE, DTD_AM_IMM, 1, 0, 5, 0, k ? 16'h0000 : 16'hf000);
			for (int c = 0; c < 16; c++) begin
				req_cc_in = 4'(c);
				issue(DTD_OP_BCOND, 0, 0, 0, 0, 0, 16'h0000);
				check("taken", 16'(dtd_xfer_i.branch_taken_out), 16'(cond(4'(c), k ? 4'h4 : 4'h8)));
			end
		end
		for (int t = 0; t < 57; t++) begin
			issue(DTD_OP_BCOND, 0, 0, 0, 0, 0, 16'h0000, 6'(t));
			e = 0;
			while (t >= lim[e]) e++;
			check("class", 16'(class_out), 16'(e));
		end
	endtask

	initial begin
		repeat (4) @(negedge clk_sys_in);
		rst_in = 1'b0;
		check("flags", 16'(flags_out), 16'h0080);
		t_move();
		t_steps();
		t_stack();
		t_refused();
		t_branch();
		finish_test();
	end
endmodule
